/* ppe_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the parallel port block.
 * Assumes inclusion by the port module and by the bench only.
 */
`ifndef PPE_MAP_SVH
`define PPE_MAP_SVH

`define PPE_OFS_DATA      8'h00
`define PPE_OFS_STATUS    8'h04
`define PPE_OFS_CONTROL   8'h08
`define PPE_OFS_EPP_ADDR  8'h0C
`define PPE_OFS_EPP_DATA  8'h10
`define PPE_OFS_COMPAT_DATA_FIFO     8'h14
`define PPE_OFS_EDFIFO    8'h18
`define PPE_OFS_TEST_FIFO     8'h1C
`define PPE_OFS_PORT_CONFIG_A     8'h20
`define PPE_OFS_PORT_CONFIG_B     8'h24
`define PPE_OFS_ECR       8'h28
`define PPE_OFS_AFIFO     8'h2C
`define PPE_OFS_EPP_CTRL  8'h30
`define PPE_OFS_CHIP_CFG  8'h34

`define PPE_CTL_STROBE    0
`define PPE_CTL_DIR       5
`define PPE_EPC_TRANSFER_DIRECTION_BIT      0
`define PPE_CFG_RELEASE   6
`define PPE_STS_TIMEOUT   0

`define PPE_CONTROL_RST   8'h00
`define PPE_EPP_CTRL_RST  8'h00
`define PPE_CHIP_CFG_RST  8'h00
`define PPE_ECR_RST       8'h00
`define PPE_PORT_CONFIG_A_VAL     8'h10
`define PPE_COMPRESS      1'b0
`define PPE_RLE_MAX       64

`define PPE_TIMEOUT_NS    10000
`define PPE_CLK_NS        10
`define PPE_TIMEOUT_CYC   (`PPE_TIMEOUT_NS / `PPE_CLK_NS)

`endif

/* ppe_peer.sv */
/* Model of the attached parallel peripheral.
   Assumes pins synchronous to the host clock; delay_i of at least one. */
`timescale 1ns/10ps
`default_nettype none
module ppe_peer (
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    input  wire ppe_pkg::ppe_pins_out_t pins_i,
    input  wire logic [11:0]            delay_i,
    input  wire logic [7:0]             rdata_i,
    input  wire logic [5:0]             side_i,
    output ppe_pkg::ppe_pins_in_t       pins_o,
    output logic [7:0]                  seen_o,
    output logic                        seen_addr_o
);
    import ppe_pkg::*;
    logic        stb;
    logic        hold;
    logic        drv;
    logic        alt;
    logic [11:0] cnt;
    assign stb = !pins_i.data_strobe_low || !pins_i.address_strobe_low;
    assign pins_o = {hold, side_i, drv ? rdata_i : {8{alt}}};
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 12'h000;
            hold <= 1'b0;
            drv <= 1'b0;
            alt <= 1'b0;
            seen_o <= 8'h00;
            seen_addr_o <= 1'b0;
        end else begin
            alt <= !alt;
            cnt <= stb ? cnt + 12'h001 : 12'h000;
            hold <= stb && (hold || cnt == delay_i);
            drv <= stb && !pins_i.data_oe;
            if (stb && cnt == 12'h000 && pins_i.data_oe) begin
                seen_o <= pins_i.data_out;
                seen_addr_o <= !pins_i.address_strobe_low;
            end
        end
    end
endmodule : ppe_peer
`default_nettype wire

/* ppe_pkg.sv */
/*
 * Types of the parallel port block: cycle states and pin groups.
 * Assumes the constants header alongside.
 */
`default_nettype none
package ppe_pkg;

    typedef enum logic [1:0] {
        PPE_IDLE,
        PPE_DRIVE,
        PPE_STROBE,
        PPE_DONE
    } ppe_state_t;

    typedef struct packed {
        logic       write_select_low;
        logic       data_strobe_low;
        logic       address_strobe_low;
        logic       peripheral_reset_low;
        logic       data_oe;
        logic [7:0] data_out;
    } ppe_pins_out_t;

    typedef struct packed {
        logic       peripheral_hold_low;
        logic       peripheral_interrupt_in;
        logic       busy;
        logic       ack_low;
        logic       paper_end;
        logic       select;
        logic       fault_low;
        logic [7:0] data_in;
    } ppe_pins_in_t;

endpackage : ppe_pkg
`default_nettype wire

/* ppe_port.sv */
/*
 * Parallel port with EPP 1.7 cycles, the shared ECP FIFO and an AHB-Lite register slave.
 * Assumes one AHB-Lite master with this slave alone, and pins synchronous to clk_i.
 */
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ppe_map.svh"

module ppe_port #(
    parameter int FIFO_DEPTH = 16,
    parameter int TIMER_W    = 16
) (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  hsel_i,
    input  wire logic [31:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    output logic [31:0]                hrdata_o,
    input  wire ppe_pkg::ppe_pins_in_t pins_i,
    output ppe_pkg::ppe_pins_out_t     pins_o,
    output logic                       irq_line_level_o
);
    import ppe_pkg::*;

    localparam int PW = $clog2(FIFO_DEPTH);
    localparam logic [TIMER_W-1:0] TO_LAST = TIMER_W'(`PPE_TIMEOUT_CYC - 1);

    ppe_state_t       state;
    logic             dp_valid;
    logic             dp_write;
    logic             dp_epp;
    logic [7:0]       dp_ofs;
    logic             ap_take;
    logic [7:0]       ap_ofs;
    logic [7:0]       port_control;
    logic [7:0]       epp_control;
    logic [7:0]       chip_config;
    logic [7:2]       ecr_ctl;
    logic             timeout_flag;
    logic [7:0]       pd_out;
    logic             cyc_dir;
    logic             cyc_addr;
    logic [TIMER_W-1:0] timer;
    logic             timeout_hit;
    logic             cycle_end;
    logic             in_cycle;
    logic             reg_wr;
    logic [7:0]       fifo_mem [FIFO_DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      fifo_count;
    logic             fifo_full;
    logic             fifo_empty;
    logic             fifo_push;
    logic             fifo_pop;

    function automatic logic is_fifo_push(input logic [7:0] ofs);
        is_fifo_push = (ofs == `PPE_OFS_COMPAT_DATA_FIFO) || (ofs == `PPE_OFS_EDFIFO) ||
                       (ofs == `PPE_OFS_TEST_FIFO) || (ofs == `PPE_OFS_AFIFO);
    endfunction : is_fifo_push

    function automatic logic is_fifo_pop(input logic [7:0] ofs);
        is_fifo_pop = (ofs == `PPE_OFS_EDFIFO) || (ofs == `PPE_OFS_TEST_FIFO);
    endfunction : is_fifo_pop

    function automatic logic is_epp(input logic [7:0] ofs);
        is_epp = (ofs == `PPE_OFS_EPP_ADDR) || (ofs == `PPE_OFS_EPP_DATA);
    endfunction : is_epp

    assign ap_take     = hsel_i && htrans_i[1] && hready_i;
    assign ap_ofs      = (haddr_i[31:8] == 24'h000000) ? haddr_i[7:0] : 8'hFF;
    assign hresp_o     = 1'b0;
    assign hreadyout_o = !(dp_valid && dp_epp && state != PPE_DONE);
    assign reg_wr      = dp_valid && dp_write && !dp_epp;

    // Data phase tracking; a new address phase is taken only when the slave is ready.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_epp   <= 1'b0;
            dp_ofs   <= 8'h00;
        end else if (hreadyout_o) begin
            dp_valid <= ap_take;
            dp_write <= hwrite_i;
            dp_epp   <= ap_take && is_epp(ap_ofs);
            dp_ofs   <= ap_ofs;
        end
    end

    // EPP cycle sequencer.
    assign in_cycle    = (state == PPE_DRIVE) || (state == PPE_STROBE);
    assign timeout_hit = (state == PPE_STROBE) && (timer >= TO_LAST);
    assign cycle_end   = (state == PPE_STROBE) && (pins_i.peripheral_hold_low || timeout_hit);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= PPE_IDLE;
        end else begin
            case (state)
                PPE_IDLE: begin
                    if (dp_valid && dp_epp) begin
                        state <= PPE_DRIVE;
                    end
                end
                PPE_DRIVE: begin
                    state <= PPE_STROBE;
                end
                PPE_STROBE: begin
                    if (cycle_end) begin
                        state <= PPE_DONE;
                    end
                end
                PPE_DONE: begin
                    state <= PPE_IDLE;
                end
                default: begin
                    state <= PPE_IDLE;
                end
            endcase
        end
    end

    // Watchdog counts from the start of the cycle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer <= '0;
        end else if (in_cycle) begin
            timer <= timer + TIMER_W'(1);
        end else begin
            timer <= '0;
        end
    end

    // Cycle attributes are frozen at the start so pins change only between cycles.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cyc_dir  <= 1'b1;
            cyc_addr <= 1'b0;
        end else if (state == PPE_IDLE && dp_valid && dp_epp) begin
            cyc_dir  <= epp_control[`PPE_EPC_TRANSFER_DIRECTION_BIT];
            cyc_addr <= (dp_ofs == `PPE_OFS_EPP_ADDR);
        end
    end

    // Port data latch: standard data writes and EPP write bytes, kept after the cycle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pd_out <= 8'h00;
        end else if (state == PPE_IDLE && dp_valid && dp_epp && dp_write) begin
            pd_out <= hwdata_i[7:0];
        end else if (reg_wr && dp_ofs == `PPE_OFS_DATA) begin
            pd_out <= hwdata_i[7:0];
        end
    end

    // Software registers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_control <= `PPE_CONTROL_RST;
            epp_control  <= `PPE_EPP_CTRL_RST;
            chip_config  <= `PPE_CHIP_CFG_RST;
            ecr_ctl      <= 6'(`PPE_ECR_RST >> 2);
        end else if (reg_wr) begin
            case (dp_ofs)
                `PPE_OFS_CONTROL:  port_control <= {2'b00, hwdata_i[5:0]};
                `PPE_OFS_EPP_CTRL: epp_control  <= {7'h00, hwdata_i[0]};
                `PPE_OFS_CHIP_CFG: chip_config  <= {1'b0, hwdata_i[6:0]};
                `PPE_OFS_ECR:      ecr_ctl      <= hwdata_i[7:2];
                default:           port_control <= port_control;
            endcase
        end
    end

    // Time-out flag; a new time-out wins over a write-one clear.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timeout_flag <= 1'b0;
        end else if (timeout_hit && !pins_i.peripheral_hold_low) begin
            timeout_flag <= 1'b1;
        end else if (reg_wr && dp_ofs == `PPE_OFS_STATUS && hwdata_i[`PPE_STS_TIMEOUT]) begin
            timeout_flag <= 1'b0;
        end
    end

    // Shared FIFO behind every FIFO view, one byte per entry.
    assign fifo_full  = (fifo_count == (PW+1)'(FIFO_DEPTH));
    assign fifo_empty = (fifo_count == '0);
    assign fifo_push  = reg_wr && is_fifo_push(dp_ofs) && !fifo_full;
    assign fifo_pop   = ap_take && hreadyout_o && !hwrite_i && is_fifo_pop(ap_ofs) && !fifo_empty;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr     <= '0;
            rd_ptr     <= '0;
            fifo_count <= '0;
        end else begin
            if (fifo_push) begin
                wr_ptr <= wr_ptr + PW'(1);
            end
            if (fifo_pop) begin
                rd_ptr <= rd_ptr + PW'(1);
            end
            if (fifo_push && !fifo_pop) begin
                fifo_count <= fifo_count + (PW+1)'(1);
            end else if (fifo_pop && !fifo_push) begin
                fifo_count <= fifo_count - (PW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (fifo_push) begin
            fifo_mem[wr_ptr] <= hwdata_i[7:0];
        end
    end

    // Read data: registers at the address phase, the captured byte at the strobe release.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_o <= 32'h00000000;
        end else if (cycle_end) begin
            hrdata_o <= {24'h000000, pins_i.data_in};
        end else if (ap_take && hreadyout_o && !hwrite_i) begin
            case (ap_ofs)
                `PPE_OFS_DATA:     hrdata_o <= {24'h000000, pins_i.data_in};
                `PPE_OFS_STATUS:   hrdata_o <= {24'h000000, !pins_i.busy, pins_i.ack_low, pins_i.paper_end,
                                                pins_i.select, pins_i.fault_low, 2'b00, timeout_flag};
                `PPE_OFS_CONTROL:  hrdata_o <= {24'h000000, port_control};
                `PPE_OFS_EDFIFO,
                `PPE_OFS_TEST_FIFO:    hrdata_o <= {24'h000000, fifo_empty ? 8'h00 : fifo_mem[rd_ptr]};
                `PPE_OFS_PORT_CONFIG_A:    hrdata_o <= {24'h000000, `PPE_PORT_CONFIG_A_VAL};
                `PPE_OFS_PORT_CONFIG_B:    hrdata_o <= {24'h000000, `PPE_COMPRESS, pins_i.peripheral_interrupt_in,
                                                chip_config[5:0]};
                `PPE_OFS_ECR:      hrdata_o <= {24'h000000, ecr_ctl, fifo_full, fifo_empty};
                `PPE_OFS_EPP_CTRL: hrdata_o <= {24'h000000, epp_control};
                `PPE_OFS_CHIP_CFG: hrdata_o <= {24'h000000, chip_config};
                default:           hrdata_o <= 32'h00000000;
            endcase
        end
    end

    // Pin drive.
    always_comb begin
        pins_o.data_out             = pd_out;
        pins_o.peripheral_reset_low = chip_config[`PPE_CFG_RELEASE];
        pins_o.data_strobe_low      = !(state == PPE_STROBE && !cyc_addr);
        pins_o.address_strobe_low   = !(state == PPE_STROBE && cyc_addr);
        if (in_cycle) begin
            pins_o.write_select_low = cyc_dir && !port_control[`PPE_CTL_STROBE];
            pins_o.data_oe          = !cyc_dir || port_control[`PPE_CTL_STROBE];
        end else begin
            pins_o.write_select_low = epp_control[`PPE_EPC_TRANSFER_DIRECTION_BIT];
            pins_o.data_oe          = !port_control[`PPE_CTL_DIR];
        end
    end

    assign irq_line_level_o = pins_i.peripheral_interrupt_in;

endmodule : ppe_port
`default_nettype wire

/* ppe_port_checker.sv */
/* Concurrent checks on the parallel port pins and bus answer.
   Assumes a bind into ppe_port and one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module ppe_port_checker (
    input wire logic                   clk_i,
    input wire logic                   resetn_i,
    input wire logic                   hreadyout_o,
    input wire logic [31:0]            hrdata_o,
    input wire ppe_pkg::ppe_pins_in_t  pins_i,
    input wire ppe_pkg::ppe_pins_out_t pins_o,
    input wire logic                   irq_line_level_o
);
    import ppe_pkg::*;
    logic        stb;
    logic [10:0] run;
    assign stb = !pins_o.data_strobe_low || !pins_o.address_strobe_low;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run <= 11'h000;
        end else begin
            run <= stb ? run + 11'h001 : 11'h000;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_stb_on;
        $rose(stb);
    endsequence
    sequence s_done;
        stb && pins_i.peripheral_hold_low;
    endsequence
    a_irq_follow: assert property (irq_line_level_o == pins_i.peripheral_interrupt_in)
        else $error("interrupt level differs from pin");
    a_one_strobe: assert property (pins_o.data_strobe_low || pins_o.address_strobe_low)
        else $error("both strobes low");
    a_stall_strobe: assert property (stb |-> !hreadyout_o)
        else $error("bus answered while strobe low");
    a_hold_ends: assert property (s_done |=> !stb && hreadyout_o)
        else $error("cycle did not end after hold release");
    a_data_first: assert property (s_stb_on ##0 !pins_o.write_select_low |-> pins_o.data_oe && $stable(pins_o.data_out))
        else $error("byte not on bus before strobe");
    a_byte_kept: assert property ($rose(stb) && pins_o.data_oe |-> $stable(pins_o.data_out) ##1 $stable(pins_o.data_out))
        else $error("written byte not kept");
    a_read_capture: assert property (s_done ##0 (pins_o.write_select_low && !pins_o.data_oe) |=> hrdata_o == {24'h000000, $past(pins_i.data_in)})
        else $error("read byte not captured");
    a_watchdog_bound: assert property (run <= 11'h3E9)
        else $error("cycle outlived the watchdog");
    a_cycle_gap: assert property ($fell(stb) |=> !stb [*2])
        else $error("new cycle started too soon");
    a_dir_drive: assert property (stb |-> pins_o.data_oe == !pins_o.write_select_low)
        else $error("bus drive disagrees with write select");
    a_dir_frozen: assert property (stb ##1 stb |-> $stable(pins_o.write_select_low))
        else $error("write select moved within a cycle");
endmodule : ppe_port_checker
bind ppe_port ppe_port_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .hreadyout_o(hreadyout_o),
    .hrdata_o(hrdata_o), .pins_i(pins_i), .pins_o(pins_o), .irq_line_level_o(irq_line_level_o));
`default_nettype wire

/* tb.sv */
/* Self-checking bench of the parallel port.
   Assumes the peripheral model and the checker alongside. */
`timescale 1ns/10ps
`default_nettype none
`include "ppe_map.svh"
module tb;
    import ppe_pkg::*;
    logic          clk_i, resetn_i, hsel, hwrite, hrdy, hresp, irq_lvl, seen_addr;
    logic          rd_ph = 1'b0;
    logic [1:0]    htrans;
    logic [31:0]   haddr, hwdata, hrdata, v;
    logic [11:0]   dly;
    logic [7:0]    rdat, seen;
    logic [5:0]    side;
    logic [63:0]   nt;
    logic [63:0]   notes[$];
    logic [7:0]    fv[0:16];
    ppe_pins_in_t  pin_in;
    ppe_pins_out_t pin_out;
    int            miscompares, compares, seed, i;
    ppe_port dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
        .hresp_o(hresp), .hrdata_o(hrdata), .pins_i(pin_in), .pins_o(pin_out), .irq_line_level_o(irq_lvl));
    ppe_peer peer_u (.clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pin_out), .delay_i(dly), .rdata_i(rdat),
        .side_i(side), .pins_o(pin_in), .seen_o(seen), .seen_addr_o(seen_addr));
    task complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hrdy !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            miscompares++;
            complete_run();
        end
    endtask : wait_rdy
    task bus(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) notes.push_back({m, e});
        wait_rdy();
    endtask : bus
    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 32'h0, 32'h0);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0, e, 32'hFFFFFFFF);
    endtask : rd
    always @(posedge clk_i) begin
        if (rd_ph && hrdy) begin
            nt = notes.pop_front();
            chk("hrdata", hrdata & nt[63:32], nt[31:0] & nt[63:32]);
            chk("hresp", hresp, 32'h0);
        end
        rd_ph <= (hsel && htrans[1] && !hwrite && hrdy) || (rd_ph && !hrdy);
    end
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        seed = 84357;
        resetn_i = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        dly = 12'h001;
        rdat = 8'h00;
        side = 6'h00;
        repeat (4) @(posedge clk_i);
        chk("periph reset", pin_out.peripheral_reset_low, 32'h0);
        chk("strobes", {pin_out.data_strobe_low, pin_out.address_strobe_low}, 32'h3);
        resetn_i <= 1'b1;
        rd(`PPE_OFS_PORT_CONFIG_A, 32'h10);
        rd(32'h3C, 32'h0);
        wr(`PPE_OFS_CONTROL, 32'h0);
        rd(`PPE_OFS_CONTROL, 32'h0);
        for (i = 0; i < 4; i++) begin
            side <= 6'($random(seed));
            @(posedge clk_i);
            rd(`PPE_OFS_STATUS, {24'h0, ~side[4], side[3:0], 3'h0});
            chk("irq level", irq_lvl, side[5]);
        end
        v = $random(seed);
        wr(`PPE_OFS_CHIP_CFG, {25'h0, 1'b1, v[5:0]});
        rd(`PPE_OFS_PORT_CONFIG_B, {24'h0, 1'b0, side[5], v[5:0]});
        chk("periph reset", pin_out.peripheral_reset_low, 32'h1);
        for (i = 0; i < 8; i++) begin
            wr(`PPE_OFS_EPP_CTRL, {31'h0, i[2]});
            v = $random(seed);
            dly <= {9'h0, v[10:8]} + 12'h001;
            rdat <= v[7:0];
            if (i[2]) rd(i[0] ? `PPE_OFS_EPP_DATA : `PPE_OFS_EPP_ADDR, {24'h0, v[7:0]});
            else wr(i[0] ? `PPE_OFS_EPP_DATA : `PPE_OFS_EPP_ADDR, {24'h0, v[7:0]});
            @(posedge clk_i);
            chk("write select", pin_out.write_select_low, i[2]);
            if (!i[2]) chk("peer byte", {seen_addr, seen, pin_out.data_out}, {!i[0], v[7:0], v[7:0]});
        end
        dly <= 12'hFFF;
        bus(`PPE_OFS_EPP_DATA, 1'b0, 32'h0, 32'h0, 32'h0);
        rd(`PPE_OFS_STATUS, {24'h0, ~side[4], side[3:0], 3'h1});
        wr(`PPE_OFS_STATUS, 32'h1);
        rd(`PPE_OFS_STATUS, {24'h0, ~side[4], side[3:0], 3'h0});
        rd(`PPE_OFS_ECR, 32'h1);
        for (i = 0; i < 17; i++) begin
            fv[i] = 8'($random(seed));
            wr(i[0] ? `PPE_OFS_COMPAT_DATA_FIFO : `PPE_OFS_EDFIFO, {24'h0, fv[i]});
        end
        rd(`PPE_OFS_ECR, 32'h2);
        for (i = 0; i < 16; i++) rd(`PPE_OFS_TEST_FIFO, {24'h0, fv[i]});
        rd(`PPE_OFS_ECR, 32'h1);
        repeat (4) @(posedge clk_i);
        complete_run();
    end
endmodule : tb
`default_nettype wire
